// ### rtl/pm_bridge.sv
// Power state control, access masking and reset defaults of the bridge
`timescale 1ns/100ps
module pm_bridge #(
   parameter logic [7:0] NEXT_PTR = 8'h00,
   parameter logic [31:0] TGT_MASK = 32'hf0000000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cfg_valid,
   input wire pm_bridge_pkg::cfg_req_t cfg_req,
   output logic cfg_ack,
   output logic cfg_retry,
   output logic [31:0] cfg_rdata,
   input wire logic cfg_devsel_in,
   input wire logic boot_strap_in,
   input wire logic sys_req,
   input wire logic [31:0] sys_addr,
   output logic sys_claim,
   output logic [31:0] pci_mem_addr,
   input wire logic mst_req,
   output logic mst_grant,
   input wire logic tgt_req,
   input wire logic [31:0] tgt_addr,
   output logic tgt_claim,
   output logic pm_reset_out,
   output logic cpu_irq,
   output logic [31:0] err_enable
);
   logic [1:0] pstate_q; // Current power state
   logic dwe_q; // Delayed write enable
   logic scr_q; // State change request flag
   logic apw_q; // Allow power write acknowledge
   logic [1:0] requested_state_field_q; // Requested state field
   logic [31:0] erren_q; // Error enable register
   logic [31:0] cmd_q; // Command register
   logic [31:0] base_q [3]; // Window bases
   logic [31:0] mask_q [3]; // Window masks, bit 0 enable
   logic [31:0] xlat_q [3]; // Window translation
   logic [31:0] bar1_q; // Target base one
   logic [31:0] bar2_q; // Target base two
   logic boot_pend_q; // First cycle after reset
   logic ds1_q, ds2_q, ds3_q; // Device select synchroniser
   logic devsel_q; // Filtered device select
   logic [2:0] rst_cnt_q; // Reset pulse counter
   logic irq_q; // Interrupt output register
   logic ack_q, retry_q; // Config answer
   logic [31:0] cfg_rdata_q;
   logic [31:0] prdata_q;
   logic slverr_q;
   logic [31:0] sys_addr_q;
   logic sys_claim_q;
   logic [31:0] rd_mux; // APB read data
   logic map_ok; // APB address mapped
   logic [2:0] win_hit;
   logic [31:0] win_xl [3];
   logic pm_wr, from_d3, unsup, seq_wr, hold, go, set_scr;
   logic [1:0] req_st;
   logic apb_wr, apb_setup;

   // APB strobes
   assign apb_setup = psel & ~penable;
   assign apb_wr = psel & penable & pwrite & map_ok;
   assign pready = 1'b1;

   // Host power write decode, only when selected
   assign pm_wr = cfg_valid & devsel_q & cfg_req.we &
                  (cfg_req.addr == pm_bridge_pkg::CFG_PMCSR);
   assign req_st = cfg_req.wdata[1:0];
   assign from_d3 = pstate_q == pm_bridge_pkg::ST_D3HOT;
   assign unsup = req_st == pm_bridge_pkg::ST_D2;
   assign seq_wr = pm_wr & ~from_d3 & ~unsup;
   assign hold = seq_wr & dwe_q & ~apw_q;
   assign go = seq_wr & (~dwe_q | apw_q);
   assign set_scr = seq_wr & ~(dwe_q & apw_q);

   // Device select pin synchroniser with agreement filter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ds1_q <= 1'b0;
         ds2_q <= 1'b0;
         ds3_q <= 1'b0;
         devsel_q <= 1'b0;
      end else begin
         ds1_q <= cfg_devsel_in;
         ds2_q <= ds1_q;
         ds3_q <= ds2_q;
         // Take the level once two stages agree
         if (ds2_q == ds3_q) begin
            devsel_q <= ds3_q;
         end
      end
   end

   // Boot strap window: one cycle after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_pend_q <= 1'b1;
      end else begin
         boot_pend_q <= 1'b0;
      end
   end

   // Power state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pstate_q <= pm_bridge_pkg::ST_D0;
      end else if (pm_wr && from_d3) begin
         pstate_q <= pm_bridge_pkg::ST_D0;
      end else if (go && req_st != pstate_q) begin
         pstate_q <= req_st;
      end
      // Unsupported requests outside D3hot leave the state as it is
   end

   // Power-management reset pulse after D3hot exit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cnt_q <= 3'h0;
      end else if (pm_wr && from_d3) begin
         rst_cnt_q <= 3'(pm_bridge_pkg::PM_RST_CYCLES);
      end else if (rst_cnt_q != 3'h0) begin
         rst_cnt_q <= rst_cnt_q - 3'h1;
      end
   end
   assign pm_reset_out = rst_cnt_q != 3'h0;

   // Handshake register; hardware set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dwe_q <= pm_bridge_pkg::HSK_DWE_RST;
         scr_q <= 1'b0;
         apw_q <= 1'b0;
         requested_state_field_q <= pm_bridge_pkg::ST_D0;
      end else begin
         if (apb_wr && paddr == pm_bridge_pkg::A_HSK) begin
            dwe_q <= pwdata[pm_bridge_pkg::HSK_DWE];
            // Flag is write one to clear
            if (pwdata[pm_bridge_pkg::HSK_SCR]) begin
               scr_q <= 1'b0;
            end
         end
         if (set_scr) begin
            scr_q <= 1'b1;
            requested_state_field_q <= req_st;
         end
         // Allow bit: software write wins over hardware clear
         if (apb_wr && paddr == pm_bridge_pkg::A_HSK) begin
            apw_q <= pwdata[pm_bridge_pkg::HSK_APW];
         end else if (go && dwe_q) begin
            apw_q <= 1'b0;
         end
      end
   end

   // Interrupt to the local processor follows the flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= scr_q | set_scr;
      end
   end
   assign cpu_irq = irq_q;

   // Error enable and command registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erren_q <= pm_bridge_pkg::ZERO32;
         cmd_q <= pm_bridge_pkg::ZERO32;
      end else begin
         if (boot_pend_q && boot_strap_in) begin
            cmd_q[pm_bridge_pkg::CMD_MEM] <= 1'b1;
         end
         if (apb_wr && paddr == pm_bridge_pkg::A_ERREN) begin
            erren_q <= pwdata;
         end
         if (apb_wr && paddr == pm_bridge_pkg::A_CMD) begin
            cmd_q <= pwdata;
         end
      end
   end
   assign err_enable = erren_q;

   // Master windows and their hit logic
   for (genvar i = 0; i < 3; i++) begin : g_win
      localparam logic [7:0] OFS = 8'(i * 16);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            base_q[i] <= pm_bridge_pkg::ZERO32;
            mask_q[i] <= pm_bridge_pkg::ZERO32;
            xlat_q[i] <= pm_bridge_pkg::ZERO32;
         end else begin
            // Boot mode opens window zero
            if (i == 0 && boot_pend_q && boot_strap_in) begin
               base_q[i] <= pm_bridge_pkg::BOOT_BASE;
               mask_q[i] <= pm_bridge_pkg::BOOT_MASK;
               xlat_q[i] <= pm_bridge_pkg::BOOT_BASE;
            end
            // Windows stay writable afterwards
            if (apb_wr && paddr == pm_bridge_pkg::A_WIN + OFS) begin
               base_q[i] <= pwdata;
            end
            if (apb_wr && paddr == pm_bridge_pkg::A_WIN + OFS + 8'h04) begin
               mask_q[i] <= pwdata;
            end
            if (apb_wr && paddr == pm_bridge_pkg::A_WIN + OFS + 8'h08) begin
               xlat_q[i] <= pwdata;
            end
         end
      end
      // Hit compares the masked upper bits
      assign win_hit[i] = mask_q[i][pm_bridge_pkg::WIN_EN] &&
         ((sys_addr & {mask_q[i][31:1], 1'b0}) ==
          (base_q[i] & {mask_q[i][31:1], 1'b0}));
      assign win_xl[i] = (xlat_q[i] & {mask_q[i][31:1], 1'b0}) |
                         (sys_addr & ~{mask_q[i][31:1], 1'b0});
   end

   // Memory cycle out of the windows, only in D0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_claim_q <= 1'b0;
         sys_addr_q <= pm_bridge_pkg::ZERO32;
      end else begin
         sys_claim_q <= sys_req && (|win_hit) &&
                        pstate_q == pm_bridge_pkg::ST_D0;
         if (win_hit[0]) begin
            sys_addr_q <= win_xl[0];
         end else if (win_hit[1]) begin
            sys_addr_q <= win_xl[1];
         end else begin
            sys_addr_q <= win_xl[2];
         end
      end
   end
   assign sys_claim = sys_claim_q;
   assign pci_mem_addr = sys_addr_q;

   // Bus mastering is gated by power state
   assign mst_grant = mst_req && cmd_q[pm_bridge_pkg::CMD_MST] &&
                      pstate_q == pm_bridge_pkg::ST_D0;

   // Target base registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bar1_q <= pm_bridge_pkg::ZERO32;
         bar2_q <= pm_bridge_pkg::ZERO32;
      end else begin
         if (apb_wr && paddr == pm_bridge_pkg::A_BAR1) begin
            bar1_q <= pwdata;
         end
         if (apb_wr && paddr == pm_bridge_pkg::A_BAR2) begin
            bar2_q <= pwdata;
         end
      end
   end
   // Target memory claim, masked outside D0
   assign tgt_claim = tgt_req && cmd_q[pm_bridge_pkg::CMD_MEM] &&
      pstate_q == pm_bridge_pkg::ST_D0 &&
      (((tgt_addr & TGT_MASK) == (bar1_q & TGT_MASK)) ||
       ((tgt_addr & TGT_MASK) == (bar2_q & TGT_MASK)));

   // Config answer: ack, retry or silence without select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q <= 1'b0;
         retry_q <= 1'b0;
         cfg_rdata_q <= pm_bridge_pkg::ZERO32;
      end else begin
         ack_q <= cfg_valid && devsel_q && !hold;
         retry_q <= hold;
         if (cfg_valid && devsel_q && !cfg_req.we) begin
            case (cfg_req.addr)
               pm_bridge_pkg::CFG_CAP: begin
                  cfg_rdata_q <= {pm_bridge_pkg::PM_CAPS_VAL, NEXT_PTR,
                     pm_bridge_pkg::CAP_ID_VAL};
               end
               pm_bridge_pkg::CFG_PMCSR: begin
                  cfg_rdata_q <= {pm_bridge_pkg::PM_DATA_VAL,
                     pm_bridge_pkg::BSE_VAL, 14'h0000,
                     pstate_q};
               end
               default: begin
                  cfg_rdata_q <= pm_bridge_pkg::ZERO32;
               end
            endcase
         end
      end
   end
   assign cfg_ack = ack_q;
   assign cfg_retry = retry_q;
   assign cfg_rdata = cfg_rdata_q;

   // APB read mux
   always_comb begin
      rd_mux = pm_bridge_pkg::ZERO32;
      map_ok = 1'b1;
      case (paddr)
         pm_bridge_pkg::A_HSK: begin
            rd_mux[pm_bridge_pkg::HSK_DWE] = dwe_q;
            rd_mux[pm_bridge_pkg::HSK_SCR] = scr_q;
            rd_mux[pm_bridge_pkg::HSK_APW] = apw_q | ~dwe_q;
            rd_mux[pm_bridge_pkg::HSK_REQ +: 2] = requested_state_field_q;
         end
         pm_bridge_pkg::A_ERREN: rd_mux = erren_q;
         pm_bridge_pkg::A_CMD: rd_mux = cmd_q;
         pm_bridge_pkg::A_STATE: rd_mux[1:0] = pstate_q;
         pm_bridge_pkg::A_BAR1: rd_mux = bar1_q;
         pm_bridge_pkg::A_BAR2: rd_mux = bar2_q;
         default: begin
            map_ok = 1'b0;
            for (int i = 0; i < 3; i++) begin
               if (paddr == pm_bridge_pkg::A_WIN + 8'(i * 16)) begin
                  rd_mux = base_q[i];
                  map_ok = 1'b1;
               end
               if (paddr == pm_bridge_pkg::A_WIN + 8'(i * 16 + 4)) begin
                  rd_mux = mask_q[i];
                  map_ok = 1'b1;
               end
               if (paddr == pm_bridge_pkg::A_WIN + 8'(i * 16 + 8)) begin
                  rd_mux = xlat_q[i];
                  map_ok = 1'b1;
               end
            end
         end
      endcase
   end

   // APB read data and error captured in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= pm_bridge_pkg::ZERO32;
         slverr_q <= 1'b0;
      end else if (apb_setup) begin
         prdata_q <= pwrite ? pm_bridge_pkg::ZERO32 : rd_mux;
         slverr_q <= ~map_ok;
      end
   end
   assign prdata = prdata_q;
   assign pslverr = slverr_q & psel & penable;

   // Checks
   sequence s_pm_write;
      pm_wr && !from_d3;
   endsequence

   a_d2_keeps_state: assert property (@(posedge pclk) disable iff (!presetn)
      (s_pm_write and unsup) |=> $stable(pstate_q))
      else $error("D2 request changed power state");
   a_d3_reset_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      (pm_wr && from_d3) |=> (pm_reset_out &&
      pstate_q == pm_bridge_pkg::ST_D0) [*4] ##1 !pm_reset_out)
      else $error("reset pulse after D3hot exit wrong");
   a_retry_on_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (s_pm_write and (!unsup && dwe_q && !apw_q)) |=>
      (cfg_retry && !cfg_ack && scr_q))
      else $error("held power write not retried");
   a_irq_from_write: assert property (@(posedge pclk) disable iff (!presetn)
      set_scr |=> cpu_irq ##1 (cpu_irq || !scr_q))
      else $error("request flag did not raise interrupt");
   a_ack_clears_apw: assert property (@(posedge pclk) disable iff (!presetn)
      (go && dwe_q && !(apb_wr && paddr == pm_bridge_pkg::A_HSK))
      |=> (!apw_q && cfg_ack))
      else $error("repeat write did not clear allow bit");
   a_mask_outside_d0: assert property (@(posedge pclk) disable iff (!presetn)
      pstate_q != pm_bridge_pkg::ST_D0 |-> (!mst_grant && !tgt_claim))
      else $error("access claimed outside D0");
   a_sys_unclaimed: assert property (@(posedge pclk) disable iff (!presetn)
      sys_claim |-> $past(pstate_q) == pm_bridge_pkg::ST_D0)
      else $error("system access claimed outside D0");
   a_devsel_needed: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg_ack || cfg_retry) |-> $past(devsel_q))
      else $error("config answered without device select");
   a_cap_id_read: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg_valid && devsel_q && !cfg_req.we &&
      cfg_req.addr == pm_bridge_pkg::CFG_CAP) |=>
      (cfg_rdata[7:0] == 8'h01 && cfg_rdata[31:16] == 16'h0202))
      else $error("capability word read wrong");
   a_irq_drops: assert property (@(posedge pclk) disable iff (!presetn)
      (!scr_q && !set_scr) |=> !cpu_irq)
      else $error("interrupt stayed without flag");
endmodule // pm_bridge

// ### common/pm_bridge_pkg.sv
// Constants and carrier types for the bridge power and init block
package pm_bridge_pkg;
   // Power states as held in the control/status field
   localparam logic [1:0] ST_D0 = 2'h0;
   localparam logic [1:0] ST_D1 = 2'h1;
   localparam logic [1:0] ST_D2 = 2'h2;
   localparam logic [1:0] ST_D3HOT = 2'h3;
   // Fixed capability contents
   localparam logic [7:0] CAP_ID_VAL = 8'h01;
   localparam logic [15:0] PM_CAPS_VAL = 16'h0202;
   localparam logic [7:0] BSE_VAL = 8'h00;
   localparam logic [7:0] PM_DATA_VAL = 8'h00;
   // Host configuration offsets
   localparam logic [7:0] CFG_CAP = 8'h40;
   localparam logic [7:0] CFG_PMCSR = 8'h44;
   // APB byte offsets
   localparam logic [7:0] A_HSK = 8'h00;
   localparam logic [7:0] A_ERREN = 8'h04;
   localparam logic [7:0] A_CMD = 8'h08;
   localparam logic [7:0] A_STATE = 8'h0c;
   localparam logic [7:0] A_WIN = 8'h10;
   localparam logic [7:0] A_BAR1 = 8'h40;
   localparam logic [7:0] A_BAR2 = 8'h44;
   // Handshake register fields
   localparam int HSK_DWE = 0;
   localparam int HSK_SCR = 1;
   localparam int HSK_APW = 2;
   localparam int HSK_REQ = 3;
   // Command register fields
   localparam int CMD_MEM = 1;
   localparam int CMD_MST = 2;
   // Window register fields and boot values
   localparam int WIN_EN = 0;
   localparam logic [31:0] BOOT_BASE = 32'hfffe0000;
   localparam logic [31:0] BOOT_MASK = 32'hfffe0001;
   // Reset values
   localparam logic HSK_DWE_RST = 1'b1;
   localparam logic [31:0] ZERO32 = 32'h00000000;
   // Power-management reset pulse length in cycles
   localparam int PM_RST_CYCLES = 4;
   // Host configuration request
   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [31:0] wdata;
   } cfg_req_t;
endpackage

// ### bench/pci_host_model.sv
// Behavioural PCI host issuing configuration requests to the bridge
`timescale 1ns/100ps
module pci_host_model (
   input wire logic pclk,
   output logic cfg_valid,
   output pm_bridge_pkg::cfg_req_t cfg_req,
   input wire logic cfg_ack,
   input wire logic cfg_retry,
   input wire logic [31:0] cfg_rdata
);
   // Quiet bus at time zero
   initial begin
      cfg_valid = 1'b0;
      cfg_req = '0;
   end
   // One request after gap idle cycles, answer awaited four cycles
   task automatic xfer(input logic we, input logic [7:0] a,
         input logic [31:0] d, input int gap, output logic ok,
         output logic rt, output logic [31:0] rd);
      ok = 1'b0;
      rt = 1'b0;
      rd = 32'h00000000;
      repeat (gap) @(posedge pclk);
      cfg_valid <= 1'b1;
      cfg_req <= {we, a, d};
      @(posedge pclk);
      cfg_valid <= 1'b0;
      // Released lines show the inverse so stale values never match
      cfg_req <= pm_bridge_pkg::cfg_req_t'(~cfg_req);
      // Answer pulses stand one cycle: look at them mid-cycle, settled
      for (int i = 0; i < 4 && !ok && !rt; i++) begin
         @(negedge pclk);
         ok = (cfg_ack === 1'b1);
         rt = (cfg_retry === 1'b1);
         rd = cfg_rdata;
      end
      // Hand back on a rising edge so the next request starts there
      @(posedge pclk);
   endtask
endmodule // pci_host_model

// ### bench/pm_bridge_test.sv
// Self-checking bench for the bridge power and init block
`timescale 1ns/100ps
module pm_bridge_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic devsel = 1'b0;
   logic strap = 1'b0;
   logic sys_req = 1'b0;
   logic [31:0] sys_addr = 32'h00000000;
   logic mst_req = 1'b0;
   logic tgt_req = 1'b0;
   logic [31:0] tgt_addr = 32'h00000000;
   logic [31:0] prdata, cfg_rdata, pci_mem_addr, err_enable;
   logic pready, pslverr, cfg_valid, cfg_ack, cfg_retry;
   logic sys_claim, mst_grant, tgt_claim, pm_reset_out, cpu_irq;
   pm_bridge_pkg::cfg_req_t cfg_req;
   int fails = 0;
   int compares = 0;
   int seed = 69;
   int rst_cnt = 0;
   logic [31:0] rd, x, a;
   logic er, ok, rt;
   // Clock of 20 ns
   always #10 pclk = ~pclk;
   // Counts cycles with the chip reset output high
   always @(posedge pclk) if (pm_reset_out === 1'b1) rst_cnt++;
   pm_bridge i_pm_bridge (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfg_valid(cfg_valid), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
      .cfg_retry(cfg_retry), .cfg_rdata(cfg_rdata),
      .cfg_devsel_in(devsel), .boot_strap_in(strap), .sys_req(sys_req),
      .sys_addr(sys_addr), .sys_claim(sys_claim),
      .pci_mem_addr(pci_mem_addr), .mst_req(mst_req),
      .mst_grant(mst_grant), .tgt_req(tgt_req), .tgt_addr(tgt_addr),
      .tgt_claim(tgt_claim), .pm_reset_out(pm_reset_out),
      .cpu_irq(cpu_irq), .err_enable(err_enable));
   pci_host_model i_pci_host_model (.pclk(pclk), .cfg_valid(cfg_valid),
      .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_retry(cfg_retry),
      .cfg_rdata(cfg_rdata));
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // APB transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] ad,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Host request with a random idle gap of zero to two cycles
   task automatic cf(input logic w, input logic [7:0] ad,
         input logic [31:0] d);
      i_pci_host_model.xfer(w, ad, d, $unsigned($random(seed)) % 3,
         ok, rt, rd);
   endtask
   // System-bus access, claim and address one cycle later
   task automatic sp(input logic [31:0] ad, input logic c,
         input logic [31:0] e);
      @(posedge pclk);
      sys_req <= 1'b1;
      sys_addr <= ad;
      @(posedge pclk);
      sys_req <= 1'b0;
      sys_addr <= ~ad;
      // Claim stands one cycle: sample it settled, mid-cycle
      @(negedge pclk);
      chk(sys_claim, c);
      if (c) chk(pci_mem_addr, e);
   endtask
   // Target and master requests, combinational answers
   task automatic tp(input logic [31:0] ad, input logic t, input logic m);
      @(posedge pclk);
      tgt_req <= 1'b1;
      mst_req <= 1'b1;
      tgt_addr <= ad;
      @(posedge pclk);
      chk({tgt_claim, mst_grant}, {t, m});
      tgt_req <= 1'b0;
      mst_req <= 1'b0;
   endtask
   // Reset for 16 cycles with the given strap
   task automatic rs(input logic s);
      presetn <= 1'b0;
      strap <= s;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask
   // Retried state change serviced by the processor, then repeated
   task automatic seq(input logic [1:0] s);
      cf(1'b1, pm_bridge_pkg::CFG_PMCSR, {30'h0, s});
      chk(rt, 1'b1);
      repeat (2) @(posedge pclk);
      chk(cpu_irq, 1'b1);
      apb(1'b0, pm_bridge_pkg::A_HSK, 32'h0);
      chk(rd[4:0], {s, 3'b011});
      apb(1'b1, pm_bridge_pkg::A_HSK, 32'h00000007);
      repeat (2) @(posedge pclk);
      chk(cpu_irq, 1'b0);
      cf(1'b1, pm_bridge_pkg::CFG_PMCSR, {30'h0, s});
      chk(ok, 1'b1);
      apb(1'b0, pm_bridge_pkg::A_HSK, 32'h0);
      chk(rd[2:0], 3'b001);
      apb(1'b0, pm_bridge_pkg::A_STATE, 32'h0);
      chk(rd[1:0], s);
      $display("Test state change %0d done", s);
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      finish_test;
   end
   // Main sequence
   initial begin
      rs(1'b1);
      chk(err_enable, 32'h0);
      apb(1'b0, pm_bridge_pkg::A_WIN + 8'h04, 32'h0);
      chk(rd, 32'hfffe0001);
      apb(1'b0, pm_bridge_pkg::A_CMD, 32'h0);
      chk(rd[1], 1'b1);
      sp(32'hfffe1234, 1'b1, 32'hfffe1234);
      apb(1'b1, pm_bridge_pkg::A_WIN + 8'h04, 32'h0);
      sp(32'hfffe1234, 1'b0, 32'h0);
      $display("Test boot window done");
      rs(1'b0);
      cf(1'b0, pm_bridge_pkg::CFG_CAP, 32'h0);
      chk({ok, rt}, 2'b00);
      devsel <= 1'b1;
      repeat (6) @(posedge pclk);
      cf(1'b0, pm_bridge_pkg::CFG_CAP, 32'h0);
      chk(rd, 32'h02020001);
      cf(1'b0, pm_bridge_pkg::CFG_PMCSR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'hf0, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      $display("Test capability done");
      for (int i = 0; i < 3; i++) begin
         x = $random(seed);
         a = {4'(i + 1), x[27:0]};
         apb(1'b1, pm_bridge_pkg::A_WIN + 8'(16 * i), {4'(i + 1), 28'h0});
         apb(1'b1, pm_bridge_pkg::A_WIN + 8'(16 * i + 4), 32'hf0000001);
         apb(1'b1, pm_bridge_pkg::A_WIN + 8'(16 * i + 8), {x[3:0], 28'h0});
         sp(a, 1'b1, {x[3:0], a[27:0]});
      end
      sp({4'h9, x[27:0]}, 1'b0, 32'h0);
      apb(1'b1, pm_bridge_pkg::A_CMD, 32'h00000006);
      apb(1'b1, pm_bridge_pkg::A_BAR1, 32'h70000000);
      apb(1'b1, pm_bridge_pkg::A_BAR2, 32'h50000000);
      tp(32'h70001000, 1'b1, 1'b1);
      tp(32'h5abc0000, 1'b1, 1'b1);
      tp(32'h90000000, 1'b0, 1'b1);
      $display("Test windows done");
      seq(pm_bridge_pkg::ST_D1);
      tp(32'h70001000, 1'b0, 1'b0);
      sp(a, 1'b0, 32'h0);
      cf(1'b0, pm_bridge_pkg::CFG_CAP, 32'h0);
      chk(ok, 1'b1);
      cf(1'b1, pm_bridge_pkg::CFG_PMCSR, 32'h00000002);
      chk(ok, 1'b1);
      apb(1'b0, pm_bridge_pkg::A_STATE, 32'h0);
      chk(rd[1:0], 2'h1);
      seq(pm_bridge_pkg::ST_D3HOT);
      cf(1'b1, pm_bridge_pkg::CFG_PMCSR, 32'h00000001);
      chk(ok, 1'b1);
      repeat (8) @(posedge pclk);
      chk(rst_cnt, pm_bridge_pkg::PM_RST_CYCLES);
      apb(1'b0, pm_bridge_pkg::A_STATE, 32'h0);
      chk(rd[1:0], 2'h0);
      apb(1'b1, pm_bridge_pkg::A_HSK, 32'h0);
      apb(1'b0, pm_bridge_pkg::A_HSK, 32'h0);
      chk(rd[2:0], 3'b100);
      cf(1'b1, pm_bridge_pkg::CFG_PMCSR, 32'h00000001);
      chk(ok, 1'b1);
      repeat (2) @(posedge pclk);
      chk(cpu_irq, 1'b1);
      apb(1'b0, pm_bridge_pkg::A_HSK, 32'h0);
      chk(rd[2:0], 3'b110);
      apb(1'b0, pm_bridge_pkg::A_STATE, 32'h0);
      chk(rd[1:0], 2'h1);
      $display("Test delayed write off done");
      finish_test;
   end
endmodule // pm_bridge_test
